/* File: common/cbp_defines.svh */
// Register offsets, field positions, reset values and timing counts of the prescaler
`ifndef CBP_DEFINES_SVH
`define CBP_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CBP_OFS_CONTROL 4'h0
`define CBP_OFS_NOM_CFG 4'h4
`define CBP_OFS_DAT_CFG 4'h8
`define CBP_OFS_STATUS 4'hc

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CBP_CTRL_ENA_BIT 0
`define CBP_CTRL_MASK 32'h00000001

// ----------------------------------------------------------------------
// Timing configuration fields
// ----------------------------------------------------------------------
`define CBP_DIV_MSB 7
`define CBP_DIV_LSB 0
`define CBP_PROP_MSB 13
`define CBP_PROP_LSB 8
`define CBP_PH1_MSB 19
`define CBP_PH1_LSB 14
`define CBP_PH2_MSB 25
`define CBP_PH2_LSB 20
`define CBP_SJW_MSB 30
`define CBP_SJW_LSB 26
`define CBP_CFG_MASK 32'h7fffffff

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CBP_RST_CONTROL 32'h00000000
`define CBP_RST_NOM_CFG 32'h0830c50a
`define CBP_RST_DAT_CFG 32'h0420c302

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define CBP_SYNC_QUANTA 8'h01
`define CBP_TQ_START 8'h01
`define CBP_RX_STAGES 3

`endif

/* File: common/cbp_pkg.sv */
// Types shared by the prescaler design files
package cbp_pkg;

  // Bit rate selected by the protocol control state machine
  typedef enum logic [1:0] {
    CBP_RATE_NOM = 2'h0,
    CBP_RATE_DATA = 2'h1,
    CBP_RATE_SEC = 2'h2
  } cbp_rate_t;

  // Current bit segment
  typedef enum logic [1:0] {
    CBP_SEG_TSEG1 = 2'b01,
    CBP_SEG_TSEG2 = 2'b10
  } cbp_seg_t;

endpackage

/* File: design/cbp_bit_counters.sv */
// Quantum counter and segment counter for one bit rate
`timescale 1ns/1ns
`include "cbp_defines.svh"

module cbp_bit_counters
  import cbp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic clear,
  input wire logic [7:0] divider,
  // Counter state
  output logic tq_edge,
  output logic [7:0] seg_cnt
);

  logic [7:0] tq_cnt_reg;
  logic [7:0] tq_cnt_next;
  logic [7:0] seg_cnt_reg;
  logic [7:0] seg_cnt_next;
  logic div_one;

  // ----------------------------------------------------------------------
  // Quantum elapsed pulse
  // ----------------------------------------------------------------------
  // Divider of one (or zero) gives a continuous pulse
  assign div_one = (divider <= 8'h01);
  assign tq_edge = run && (div_one || (tq_cnt_reg == divider));

  // Next counter values; clear beats run
  assign tq_cnt_next = clear ? `CBP_TQ_START :
                       (!run || div_one) ? tq_cnt_reg :
                       tq_edge ? `CBP_TQ_START : tq_cnt_reg + 8'h01;
  assign seg_cnt_next = clear ? 8'h00 :
                        tq_edge ? seg_cnt_reg + 8'h01 : seg_cnt_reg;
  assign seg_cnt = seg_cnt_reg;

  // ----------------------------------------------------------------------
  // Counter registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tq_cnt_reg <= `CBP_TQ_START;
      seg_cnt_reg <= 8'h00;
    end
    else
    begin
      tq_cnt_reg <= tq_cnt_next;
      seg_cnt_reg <= seg_cnt_next;
    end
  end

endmodule // cbp_bit_counters

/* File: design/cbp_prescaler.sv */
// Bit timing prescaler with nominal and data timing logic and Avalon-MM registers
`timescale 1ns/1ns
`include "cbp_defines.svh"

module cbp_prescaler
  import cbp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Protocol control side
  input wire cbp_rate_t rate_sel,
  input wire logic rate_switch,
  input wire logic sync_edge,
  input wire logic hard_sync_mode,
  // Bit triggers
  output logic tx_trigger,
  output logic [2:0] rx_trigger,
  output logic sec_sample
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Byte-lane merge of a write into a register
  function automatic logic [31:0] f_merge(input logic [31:0] old_val,
                                         input logic [31:0] new_val,
                                         input logic [3:0] be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[i*8 +: 8] = new_val[i*8 +: 8];
    end
    return res;
  endfunction

  // TSEG1 length: sync plus prop plus phase 1
  function automatic logic [7:0] f_tseg1(input logic [31:0] cfg);
    return `CBP_SYNC_QUANTA + {2'h0, cfg[`CBP_PROP_MSB:`CBP_PROP_LSB]}
           + {2'h0, cfg[`CBP_PH1_MSB:`CBP_PH1_LSB]};
  endfunction

  // TSEG2 length: phase 2
  function automatic logic [7:0] f_tseg2(input logic [31:0] cfg);
    return {2'h0, cfg[`CBP_PH2_MSB:`CBP_PH2_LSB]};
  endfunction

  // Jump width
  function automatic logic [7:0] f_sjw(input logic [31:0] cfg);
    return {3'h0, cfg[`CBP_SJW_MSB:`CBP_SJW_LSB]};
  endfunction

  // End request of the segment meter
  function automatic logic f_end_req(input logic [7:0] cnt, input logic [7:0] exp_len);
    return (exp_len == 8'h00) || (cnt >= exp_len - 8'h01);
  endfunction

  // Next expected segment length of one meter
  function automatic logic [7:0] f_exp_next(input logic [31:0] cfg,
                                            input logic [7:0] exp_len,
                                            input logic [7:0] cnt,
                                            input logic in_t2,
                                            input logic enabled,
                                            input logic end_now,
                                            input logic early,
                                            input logic hard,
                                            input logic rsync);
    logic [7:0] sjw;
    logic [7:0] res;
    sjw = f_sjw(cfg);
    res = exp_len;
    if (!enabled)
      res = f_tseg1(cfg);
    else if (hard)
      res = f_tseg1(cfg) - 8'h01;
    else if (end_now)
    begin
      if (in_t2)
        res = early ? f_tseg1(cfg) - 8'h01 : f_tseg1(cfg);
      else
        res = f_tseg2(cfg);
    end
    else if (rsync && !in_t2 && cnt != 8'h00)
      res = exp_len + ((cnt > sjw) ? sjw : cnt);
    else if (rsync && in_t2)
      res = exp_len - sjw;
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [31:0] control_reg;
  logic [31:0] control_next;
  logic [31:0] nom_cfg_reg;
  logic [31:0] nom_cfg_next;
  logic [31:0] dat_cfg_reg;
  logic [31:0] dat_cfg_next;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;
  logic waitrequest_reg;
  logic waitrequest_next;
  logic [7:0] exp_nom_reg;
  logic [7:0] exp_nom_next;
  logic [7:0] exp_dat_reg;
  logic [7:0] exp_dat_next;
  cbp_seg_t seg_reg;
  cbp_seg_t seg_next;
  logic edge_used_reg;
  logic edge_used_next;
  logic tx_trigger_reg;
  logic [2:0] rx_trigger_reg;
  logic sec_sample_reg;

  logic core_en;
  logic bus_req;
  logic bus_go;
  logic wr_go;
  logic hit_control;
  logic hit_nom;
  logic hit_dat;
  logic hit_status;
  logic [31:0] status_word;
  logic [31:0] read_mux;
  logic run_nom;
  logic run_dat;
  logic clear_cnt;
  logic tq_nom;
  logic tq_dat;
  logic [7:0] seg_cnt_nom;
  logic [7:0] seg_cnt_dat;
  logic data_active;
  logic tq_act;
  logic [7:0] cnt_act;
  logic [7:0] exp_act;
  logic [7:0] sjw_act;
  logic [7:0] rem_act;
  logic in_tseg2;
  logic edge_ok;
  logic hard_sync;
  logic resync;
  logic imm_end;
  logic early_end;
  logic reg_end;
  logic seg_end;
  logic sample_point;
  logic bit_start;

  // ----------------------------------------------------------------------
  // Avalon-MM decode
  // ----------------------------------------------------------------------
  // One wait cycle, then the access completes
  assign bus_req = avs_read || avs_write;
  assign bus_go = bus_req && !waitrequest_reg;
  assign wr_go = avs_write && !waitrequest_reg;
  assign hit_control = (avs_address == `CBP_OFS_CONTROL);
  assign hit_nom = (avs_address == `CBP_OFS_NOM_CFG);
  assign hit_dat = (avs_address == `CBP_OFS_DAT_CFG);
  assign hit_status = (avs_address == `CBP_OFS_STATUS);
  assign waitrequest_next = !(bus_req && waitrequest_reg);

  // Register writes; timing configs locked while enabled
  assign control_next = (wr_go && hit_control) ?
                        f_merge(control_reg, avs_writedata, avs_byteenable) & `CBP_CTRL_MASK :
                        control_reg;
  assign nom_cfg_next = (wr_go && hit_nom && !core_en) ?
                        f_merge(nom_cfg_reg, avs_writedata, avs_byteenable) & `CBP_CFG_MASK :
                        nom_cfg_reg;
  assign dat_cfg_next = (wr_go && hit_dat && !core_en) ?
                        f_merge(dat_cfg_reg, avs_writedata, avs_byteenable) & `CBP_CFG_MASK :
                        dat_cfg_reg;

  // Status word and read mux; unmapped reads zero
  assign status_word = {4'h0, rate_sel, edge_used_reg, in_tseg2, exp_act,
                        seg_cnt_dat, seg_cnt_nom};
  assign read_mux = hit_control ? control_reg :
                    hit_nom ? nom_cfg_reg :
                    hit_dat ? dat_cfg_reg :
                    hit_status ? status_word : 32'h00000000;
  assign readdata_next = (avs_read && waitrequest_reg) ? read_mux : readdata_reg;

  // ----------------------------------------------------------------------
  // Rate selection and counter enables
  // ----------------------------------------------------------------------
  assign core_en = control_reg[`CBP_CTRL_ENA_BIT];
  // Data and secondary rates share the data logic
  assign data_active = (rate_sel != CBP_RATE_NOM);
  assign run_nom = core_en;
  assign run_dat = core_en && (data_active || rate_switch);
  assign clear_cnt = !core_en || seg_end || hard_sync;

  // Nominal counter unit
  cbp_bit_counters u_nominal_counter_unit
  (
    .clock(clock),
    .rst_n(rst_n),
    .run(run_nom),
    .clear(clear_cnt),
    .divider(nom_cfg_reg[`CBP_DIV_MSB:`CBP_DIV_LSB]),
    .tq_edge(tq_nom),
    .seg_cnt(seg_cnt_nom)
  );

  // Data counter unit
  cbp_bit_counters u_data_counter_unit
  (
    .clock(clock),
    .rst_n(rst_n),
    .run(run_dat),
    .clear(clear_cnt),
    .divider(dat_cfg_reg[`CBP_DIV_MSB:`CBP_DIV_LSB]),
    .tq_edge(tq_dat),
    .seg_cnt(seg_cnt_dat)
  );

  // ----------------------------------------------------------------------
  // Segment meter of the active rate
  // ----------------------------------------------------------------------
  assign tq_act = data_active ? tq_dat : tq_nom;
  assign cnt_act = data_active ? seg_cnt_dat : seg_cnt_nom;
  assign exp_act = data_active ? exp_dat_reg : exp_nom_reg;
  assign sjw_act = data_active ? f_sjw(dat_cfg_reg) : f_sjw(nom_cfg_reg);
  assign rem_act = exp_act - cnt_act;
  assign in_tseg2 = (seg_reg == CBP_SEG_TSEG2);

  // One edge between two sample points
  assign edge_ok = core_en && sync_edge && !edge_used_reg;
  assign hard_sync = edge_ok && hard_sync_mode;
  assign resync = edge_ok && !hard_sync_mode;

  // Negative error within jump width ends TSEG2 at once
  assign imm_end = resync && in_tseg2 && (rem_act <= sjw_act);
  assign early_end = imm_end && (rem_act < sjw_act);
  assign reg_end = tq_act && f_end_req(cnt_act, exp_act);
  assign seg_end = core_en && !hard_sync && (reg_end || imm_end);
  assign sample_point = seg_end && !in_tseg2;
  assign bit_start = (seg_end && in_tseg2) || hard_sync;

  // Expected length of both meters
  assign exp_nom_next = f_exp_next(nom_cfg_reg, exp_nom_reg, seg_cnt_nom, in_tseg2, core_en,
                                   seg_end, early_end, hard_sync,
                                   resync && !imm_end && !data_active);
  assign exp_dat_next = f_exp_next(dat_cfg_reg, exp_dat_reg, seg_cnt_dat, in_tseg2, core_en,
                                   seg_end, early_end, hard_sync,
                                   resync && !imm_end && data_active);

  // Edge lock; a new edge wins over the sample point clear
  assign edge_used_next = !core_en ? 1'b0 :
                          edge_ok ? 1'b1 :
                          sample_point ? 1'b0 : edge_used_reg;

  // Segment sequence
  always_comb
  begin
    seg_next = seg_reg;
    if (!core_en || hard_sync)
      seg_next = CBP_SEG_TSEG1;
    else if (seg_end)
    begin
      unique case (seg_reg)
        CBP_SEG_TSEG1: seg_next = CBP_SEG_TSEG2;
        CBP_SEG_TSEG2: seg_next = CBP_SEG_TSEG1;
        default: seg_next = CBP_SEG_TSEG1;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Bus registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_reg <= `CBP_RST_CONTROL;
      nom_cfg_reg <= `CBP_RST_NOM_CFG;
      dat_cfg_reg <= `CBP_RST_DAT_CFG;
      readdata_reg <= 32'h00000000;
      waitrequest_reg <= 1'b1;
    end
    else
    begin
      control_reg <= control_next;
      nom_cfg_reg <= nom_cfg_next;
      dat_cfg_reg <= dat_cfg_next;
      readdata_reg <= readdata_next;
      waitrequest_reg <= waitrequest_next;
    end
  end

  // ----------------------------------------------------------------------
  // Meter and sequence registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exp_nom_reg <= 8'h00;
      exp_dat_reg <= 8'h00;
      seg_reg <= CBP_SEG_TSEG1;
      edge_used_reg <= 1'b0;
    end
    else
    begin
      exp_nom_reg <= exp_nom_next;
      exp_dat_reg <= exp_dat_next;
      seg_reg <= seg_next;
      edge_used_reg <= edge_used_next;
    end
  end

  // ----------------------------------------------------------------------
  // Trigger registers
  // ----------------------------------------------------------------------
  // Receive stages follow the sample point one cycle apart
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_trigger_reg <= 1'b0;
      rx_trigger_reg <= 3'h0;
      sec_sample_reg <= 1'b0;
    end
    else
    begin
      tx_trigger_reg <= bit_start;
      rx_trigger_reg <= {rx_trigger_reg[1:0], sample_point};
      sec_sample_reg <= sample_point && (rate_sel == CBP_RATE_SEC);
    end
  end

  // Outputs straight from flip-flops
  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = waitrequest_reg;
  assign tx_trigger = tx_trigger_reg;
  assign rx_trigger = rx_trigger_reg;
  assign sec_sample = sec_sample_reg;

endmodule // cbp_prescaler

/* File: tb/cbp_pc_model.sv */
// Protocol control model that picks the bit rate and forwards bus edges
`timescale 1ns/1ns
module cbp_pc_model
  import cbp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Requests from the bench
  input wire cbp_rate_t req_rate,
  input wire logic req_edge,
  input wire logic req_hard,
  // Triggers from the prescaler
  input wire logic tx_trigger,
  input wire logic sample,
  // Outputs to the prescaler
  output cbp_rate_t rate_sel,
  output logic rate_switch,
  output logic sync_edge,
  output logic hard_sync_mode
);
  // ----------------------------------------------------------------------
  // Rate changes only at a sample point; switch flag lasts to bit end
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rate_sel <= CBP_RATE_NOM;
      rate_switch <= 1'b0;
      sync_edge <= 1'b0;
      hard_sync_mode <= 1'b0;
    end
    else
    begin
      sync_edge <= req_edge;
      hard_sync_mode <= req_hard;
      if (sample && rate_sel != req_rate)
      begin
        rate_sel <= req_rate;
        rate_switch <= 1'b1;
      end
      else if (tx_trigger)
        rate_switch <= 1'b0;
    end
  end
endmodule // cbp_pc_model

/* File: tb/cbp_prescaler_sva.sv */
// Concurrent checks on the prescaler ports
`timescale 1ns/1ns
module cbp_prescaler_sva
  import cbp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Rate and triggers
  input wire cbp_rate_t rate_sel,
  input wire logic tx_trigger,
  input wire logic [2:0] rx_trigger,
  input wire logic sec_sample
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_wait_one: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait state");
  a_wait_idle: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest dropped without a request");
  a_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_rx_stage: assert property (rx_trigger[0] |=> rx_trigger[1] ##1 rx_trigger[2])
    else $error("receive stage triggers out of order");
  a_rx_cause: assert property (rx_trigger[2] |-> $past(rx_trigger[1]))
    else $error("last stage trigger without its predecessor");
  a_sec_with_rx: assert property (sec_sample |-> rx_trigger[0])
    else $error("secondary sample apart from sample point");
  a_sec_rate: assert property (sec_sample |-> $past(rate_sel) == CBP_RATE_SEC)
    else $error("secondary sample outside secondary rate");
  a_rst_quiet: assert property ($rose(rst_n) |-> avs_waitrequest && !tx_trigger && rx_trigger == 3'h0)
    else $error("outputs not quiet after reset");

  // Main scenarios reached
  c_tx: cover property (tx_trigger);
  c_sec: cover property (sec_sample);
  c_rx: cover property (rx_trigger[0] ##1 rx_trigger[1]);
endmodule // cbp_prescaler_sva

bind cbp_prescaler cbp_prescaler_sva u_cbp_prescaler_sva (.clock(clock), .rst_n(rst_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .rate_sel(rate_sel), .tx_trigger(tx_trigger),
  .rx_trigger(rx_trigger), .sec_sample(sec_sample));

/* File: tb/test_cbp_prescaler.sv */
// Self-checking bench for the bit timing prescaler
`timescale 1ns/1ns
`include "cbp_defines.svh"
module test_cbp_prescaler
  import cbp_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n, avs_read, avs_write, req_edge, req_hard, rate_switch, sync_edge, hard_sync_mode;
  logic [3:0] avs_address, avs_byteenable, be;
  logic [31:0] avs_writedata, avs_readdata, cfg, w, e;
  logic avs_waitrequest, tx_trigger, sec_sample;
  logic [2:0] rx_trigger;
  cbp_rate_t rate_sel, req_rate, rt;
  logic [7:0] v[8];
  int num_errors, check_count, meas, cyc, last_tx, last_rx, tx_cnt, sec_cnt, n;
  logic [31:0] exp_q[$];

  always #5 clock = ~clock;

  cbp_prescaler u_cbp_prescaler (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rate_sel(rate_sel), .rate_switch(rate_switch),
    .sync_edge(sync_edge), .hard_sync_mode(hard_sync_mode), .tx_trigger(tx_trigger),
    .rx_trigger(rx_trigger), .sec_sample(sec_sample));

  cbp_pc_model u_cbp_pc_model (.clock(clock), .rst_n(rst_n), .req_rate(req_rate),
    .req_edge(req_edge), .req_hard(req_hard), .tx_trigger(tx_trigger),
    .sample(rx_trigger[0]), .rate_sel(rate_sel), .rate_switch(rate_switch),
    .sync_edge(sync_edge), .hard_sync_mode(hard_sync_mode));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task report_and_stop();
    $display("Counts: %0d checks, %0d errors", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Holds the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    int k;
    @(posedge clock);
    avs_address <= adr;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 100);
    if (k >= 100)
      num_errors++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] adr, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, adr, 32'h0);
  endtask

  function automatic logic [31:0] mk(input logic [7:0] d, input logic [5:0] p,
    input logic [5:0] a, input logic [5:0] b, input logic [4:0] s);
    return {1'b0, s, b, a, p, d};
  endfunction

  // Waits until the monitor has consumed all timing notes
  task automatic wait_done();
    int k;
    // Lets a note count set on this edge land first
    @(posedge clock);
    k = 0;
    while (meas != 0 && k < 3000)
    begin
      @(posedge clock);
      k++;
    end
    if (k >= 3000)
      num_errors++;
  endtask

  // Notes n bits of segment lengths in clocks, starting at a bit start
  task automatic bits(input int t1, input int t2, input int nb);
    @(posedge clock iff tx_trigger === 1'b1);
    repeat (nb)
    begin
      exp_q.push_back(t1);
      exp_q.push_back(t2);
    end
    meas <= 2 * nb;
    wait_done();
  endtask

  task automatic pulse();
    @(posedge clock);
    req_edge <= 1'b1;
    @(posedge clock);
    req_edge <= 1'b0;
  endtask

  task automatic note(input int d, input logic is_tx);
    if (meas > 0)
    begin
      check(d, exp_q.pop_front());
      meas--;
    end
    if (is_tx)
      last_tx = cyc;
    else
      last_rx = cyc;
  endtask

  // ----------------------------------------------------------------------
  // Monitor: read data and segment spacing against the oldest note
  // ----------------------------------------------------------------------
  always @(posedge clock)
  begin
    cyc++;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      check(avs_readdata, exp_q.pop_front());
    if (sec_sample === 1'b1)
      sec_cnt++;
    if (rx_trigger[0] === 1'b1)
      note(cyc - last_tx, 1'b0);
    if (tx_trigger === 1'b1)
    begin
      tx_cnt++;
      note(cyc - last_rx, 1'b1);
    end
  end

  // Watchdog
  initial
  begin
    repeat (60000) @(posedge clock);
    num_errors++;
    report_and_stop();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    req_rate = CBP_RATE_NOM;
    req_edge = 1'b0;
    req_hard = 1'b0;
    void'($urandom(77));
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(`CBP_OFS_CONTROL, `CBP_RST_CONTROL);
    rd(`CBP_OFS_NOM_CFG, `CBP_RST_NOM_CFG);
    rd(`CBP_OFS_DAT_CFG, `CBP_RST_DAT_CFG);
    rd({2'($urandom()), 2'($urandom_range(3, 1))}, 32'h0);
    cfg = mk(8'h03, 6'h04, 6'h03, 6'h05, 5'h02);
    bus(1'b1, `CBP_OFS_NOM_CFG, cfg);
    bus(1'b1, `CBP_OFS_CONTROL, 32'h1);
    bus(1'b1, `CBP_OFS_NOM_CFG, $urandom());
    rd(`CBP_OFS_NOM_CFG, cfg);
    bits(24, 15, 2);
    // Hard sync, then a second edge before the sample point is ignored
    req_hard <= 1'b1;
    @(posedge clock iff rx_trigger[0] === 1'b1);
    exp_q.push_back(4);
    exp_q.push_back(21);
    exp_q.push_back(15);
    meas <= 3;
    pulse();
    repeat (2) @(posedge clock);
    pulse();
    wait_done();
    // Negative resync early in phase 2
    req_hard <= 1'b0;
    @(posedge clock iff rx_trigger[0] === 1'b1);
    exp_q.push_back(9);
    exp_q.push_back(24);
    meas <= 2;
    pulse();
    wait_done();
    // Positive resync in the middle of the first segment
    @(posedge clock iff tx_trigger === 1'b1);
    exp_q.push_back(30);
    exp_q.push_back(15);
    meas <= 2;
    repeat (8) @(posedge clock);
    pulse();
    wait_done();
    // Random timings for both rates, divider one first
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, `CBP_OFS_CONTROL, 32'h0);
      repeat (2) @(posedge clock);
      n = tx_cnt;
      repeat (100) @(posedge clock);
      check(tx_cnt - n, 32'h0);
      for (int j = 0; j < 8; j += 4)
      begin
        v[j] = (i == 0) ? 8'h01 : 8'($urandom_range(4, 2));
        v[j + 1] = 8'($urandom_range(4, 1));
        v[j + 2] = 8'($urandom_range(4, 1));
        v[j + 3] = 8'($urandom_range(5, 2));
      end
      cfg = mk(v[0], v[1][5:0], v[2][5:0], v[3][5:0], 5'h01);
      bus(1'b1, `CBP_OFS_NOM_CFG, cfg);
      rd(`CBP_OFS_NOM_CFG, cfg);
      cfg = mk(v[4], v[5][5:0], v[6][5:0], v[7][5:0], 5'h01);
      bus(1'b1, `CBP_OFS_DAT_CFG, cfg);
      rd(`CBP_OFS_DAT_CFG, cfg);
      // Partial write: only the enabled byte lanes change
      be = 4'($urandom());
      w = $urandom();
      e = cfg;
      for (int b = 0; b < 4; b++)
      begin
        if (be[b])
          e[b*8 +: 8] = w[b*8 +: 8];
      end
      avs_byteenable <= be;
      bus(1'b1, `CBP_OFS_DAT_CFG, w);
      avs_byteenable <= 4'hf;
      rd(`CBP_OFS_DAT_CFG, e & `CBP_CFG_MASK);
      bus(1'b1, `CBP_OFS_DAT_CFG, cfg);
      bus(1'b1, `CBP_OFS_CONTROL, 32'h1);
      bits((1 + v[1] + v[2]) * v[0], v[3] * v[0], 2);
      rt = (i == 1) ? CBP_RATE_SEC : CBP_RATE_DATA;
      req_rate <= rt;
      repeat (2) @(posedge clock iff tx_trigger === 1'b1);
      n = sec_cnt;
      bits((1 + v[5] + v[6]) * v[4], v[7] * v[4], 2);
      // One sample point before the measured bits, two inside them
      check(sec_cnt - n, (rt == CBP_RATE_SEC) ? 32'h3 : 32'h0);
      req_rate <= CBP_RATE_NOM;
      repeat (2) @(posedge clock iff tx_trigger === 1'b1);
    end
    report_and_stop();
  end
endmodule // test_cbp_prescaler
